/* src/chr_pkg.sv */
// Purpose: Constants, types and state layout of the codec host register bank.
// Assumes: One 125 MHz clock; serial host pins are asynchronous to it.
// Notes: Register addresses are 8-bit address/command byte values.
// Function
// - Host threshold for voice activity detector is limited to 32767; negative words give 32767.
// - Signed host encoder offset is added to the encoder input signal.
// - Zero offset with compensation enabled freezes the current offset estimate.
// - Current encoder offset estimate is readable in its own read-only register.
// - Host word is applied directly as the encoder converter input.
// - Host ADM test byte feeds transcoding; refill need raises interrupt when enabled.
// - Reading the status register clears any pending interrupt request.
// - Data flags 5, 4, 1, 0 clear on access of their data register.
// - Voice flags 6 and 2 track detection; any change requests an interrupt.
// - Status bits 7 and 3 always read zero.
// - Encoder bits 5, 4 mean data available, or needed when transcoding.
// - Decoder bits 1, 0 mean data needed, or available when transcoding.
// - Envelope level registers report non-positive values, 0 down to -32768.
// - Decoder offset readback returns the decoder offset level supplied by the datapath.
// - Decoder linear PCM register updates raise interrupt when control bit 1 set.
// - Decoder ADM byte updates each eighth bit; interrupt when control bit 0 set.
// - PCM to ADM transcoded bits are delivered through the decoder ADM byte.
// - Offset value scales as voltage times 2^18 over full-scale reference.
// - Transfers are address byte then one or two data bytes, MSB first.
package chr_pkg;

  // ==========================================================================
  // Register addresses
  localparam logic [7:0] ADDR_STATUS    = 8'h80;
  localparam logic [7:0] ADDR_DEC_ENV   = 8'hd4;
  localparam logic [7:0] ADDR_DEC_OFS   = 8'hd5;
  localparam logic [7:0] ADDR_DEC_PCM   = 8'hd6;
  localparam logic [7:0] ADDR_DEC_ADM   = 8'hda;
  localparam logic [7:0] ADDR_ENC_THR   = 8'he2;
  localparam logic [7:0] ADDR_ENC_OFS   = 8'he3;
  localparam logic [7:0] ADDR_ENC_ENV   = 8'he4;
  localparam logic [7:0] ADDR_ENC_EST   = 8'he5;
  localparam logic [7:0] ADDR_ENC_PCM   = 8'he6;
  localparam logic [7:0] ADDR_ENC_CONV  = 8'he7;
  localparam logic [7:0] ADDR_ENC_ADMT  = 8'he8;
  localparam logic [7:0] ADDR_ENC_ADMO  = 8'hea;

  // ==========================================================================
  // Field positions and limits
  localparam int FLG_ENC_PCM = 3;
  localparam int FLG_ENC_ADM = 2;
  localparam int FLG_DEC_PCM = 1;
  localparam int FLG_DEC_ADM = 0;
  localparam int INT_ENC_PCM = 5;
  localparam int INT_ENC_ADM = 4;
  localparam int INT_DEC_PCM = 1;
  localparam int INT_DEC_ADM = 0;
  localparam logic [4:0]  BITS_NONE  = 5'h00;
  localparam logic [4:0]  BITS_BYTE  = 5'h08;
  localparam logic [4:0]  BITS_WORD  = 5'h10;
  localparam logic [4:0]  ADDR_LAST  = 5'h07;
  localparam logic [2:0]  ADM_LAST   = 3'h7;
  localparam logic [15:0] THR_MAX    = 16'h7fff;
  localparam logic [15:0] S16_MAX    = 16'h7fff;
  localparam logic [15:0] S16_MIN    = 16'h8000;
  localparam logic [15:0] ZERO16     = 16'h0000;
  localparam logic [15:0] ONE16      = 16'h0001;
  localparam logic [15:0] MINUS1_16  = 16'hffff;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    PH_ADDR  = 2'b00,
    PH_WDATA = 2'b01,
    PH_RDATA = 2'b10,
    PH_SKIP  = 2'b11
  } chr_phase_t;

  typedef struct packed {
    logic [15:0] encSample;
    logic        encSampleValid;
    logic        offCompEn;
    logic [15:0] decEnvLevel;
    logic [15:0] encEnvLevel;
    logic [15:0] decOffsetLevel;
    logic [15:0] decPcm;
    logic        decPcmValid;
    logic        decAdmBit;
    logic        decAdmBitValid;
    logic        encAdmTaken;
    logic [3:0]  flagEvent;
    logic        encVoice;
    logic        decVoice;
    logic        decTranscode;
    logic [7:0]  intCtrl;
  } chr_dp_in_t;

  typedef struct packed {
    logic [15:0] vadThreshold;
    logic [15:0] encAdjSample;
    logic        encAdjValid;
    logic [15:0] convWord;
    logic        convStrobe;
    logic [7:0]  admTestByte;
    logic        admTestStrobe;
  } chr_enc_out_t;

  typedef struct packed {
    logic [2:0]   csSync;
    logic [2:0]   sckSync;
    logic [2:0]   datSync;
    logic         csLvl;
    logic         sckLvl;
    chr_phase_t   phase;
    logic [4:0]   bitCnt;
    logic [4:0]   dataBits;
    logic [7:0]   addr;
    logic [15:0]  shiftIn;
    logic [15:0]  shiftOut;
    logic         replyData;
    logic         replyOe;
    chr_enc_out_t enc;
    logic [15:0]  encOffset;
    logic [15:0]  offEst;
    logic [15:0]  decPcm;
    logic [7:0]   decAdm;
    logic [7:0]   admShift;
    logic [2:0]   admCnt;
    logic [3:0]   flags;
    logic [1:0]   voice;
    logic         irq;
  } chr_state_t;

  localparam chr_state_t ST_RESET = '0;

endpackage : chr_pkg

/* src/chr_regs.sv */
// Purpose: Host serial register bank between host and encoder/decoder path.
// Assumes: Host pins are sampled with three flops; datapath is on clk.
// Notes: Reply data changes after the serial clock falls.
`timescale 1ns/10ps
module chr_regs (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               csN,
  input  wire logic               serialClk,
  input  wire logic               cmdData,
  output logic                    replyData,
  output logic                    replyOe,
  output logic                    irq,
  input  wire chr_pkg::chr_dp_in_t dpIn,
  output chr_pkg::chr_enc_out_t   encOut
);

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] satAdd(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] sum;
    sum = {a[15], a} + {b[15], b};
    if (sum[16] != sum[15]) begin
      satAdd = sum[16] ? chr_pkg::S16_MIN : chr_pkg::S16_MAX;
    end else begin
      satAdd = sum[15:0];
    end
  endfunction : satAdd

  function automatic logic [15:0] nonPos(input logic [15:0] v);
    nonPos = (v[15] || v == chr_pkg::ZERO16) ? v : chr_pkg::ZERO16;
  endfunction : nonPos

  function automatic logic [4:0] accessBits(input logic [7:0] a);
    unique case (a)
      chr_pkg::ADDR_STATUS, chr_pkg::ADDR_DEC_ADM, chr_pkg::ADDR_ENC_ADMO,
      chr_pkg::ADDR_ENC_ADMT:  accessBits = chr_pkg::BITS_BYTE;
      chr_pkg::ADDR_DEC_ENV, chr_pkg::ADDR_DEC_OFS, chr_pkg::ADDR_DEC_PCM,
      chr_pkg::ADDR_ENC_THR, chr_pkg::ADDR_ENC_OFS, chr_pkg::ADDR_ENC_ENV,
      chr_pkg::ADDR_ENC_EST, chr_pkg::ADDR_ENC_PCM,
      chr_pkg::ADDR_ENC_CONV: accessBits = chr_pkg::BITS_WORD;
      default:                 accessBits = chr_pkg::BITS_NONE;
    endcase
  endfunction : accessBits

  function automatic logic isWrite(input logic [7:0] a);
    isWrite = (a == chr_pkg::ADDR_ENC_THR) || (a == chr_pkg::ADDR_ENC_OFS) ||
              (a == chr_pkg::ADDR_ENC_CONV) || (a == chr_pkg::ADDR_ENC_ADMT);
  endfunction : isWrite

  // ==========================================================================
  // State
  chr_pkg::chr_state_t s;
  chr_pkg::chr_state_t next_s;

  logic        sckRise;
  logic        sckFall;
  logic        datBit;
  logic [7:0]  acByte;
  logic [15:0] wrWord;
  logic [15:0] rdWord;
  logic [7:0]  statusByte;
  logic [3:0]  flagSet;
  logic [3:0]  flagClr;
  logic [3:0]  flagIntEn;
  logic        irqSet;
  logic        irqClr;
  logic [15:0] adj;

  // ==========================================================================
  // Next state
  always_comb begin
    next_s = s;
    flagSet = s.flags & '0;
    flagClr = s.flags & '0;
    irqSet = 1'b0;
    irqClr = 1'b0;
    next_s.enc.convStrobe = 1'b0;
    next_s.enc.admTestStrobe = 1'b0;
    next_s.enc.encAdjValid = 1'b0;

    // Pin synchronisers; a level counts once the second and third flops agree.
    next_s.csSync = {s.csSync[1:0], csN};
    next_s.sckSync = {s.sckSync[1:0], serialClk};
    next_s.datSync = {s.datSync[1:0], cmdData};
    if (s.csSync[1] == s.csSync[2]) begin
      next_s.csLvl = s.csSync[2];
    end
    if (s.sckSync[1] == s.sckSync[2]) begin
      next_s.sckLvl = s.sckSync[2];
    end
    sckRise = s.sckSync[1] && s.sckSync[2] && !s.sckLvl;
    sckFall = !s.sckSync[1] && !s.sckSync[2] && s.sckLvl;
    datBit = s.datSync[2];
    acByte = {s.shiftIn[6:0], datBit};
    wrWord = {s.shiftIn[14:0], datBit};

    statusByte = {1'b0, s.voice[1], s.flags[chr_pkg::FLG_ENC_PCM],
                  s.flags[chr_pkg::FLG_ENC_ADM], 1'b0, s.voice[0],
                  s.flags[chr_pkg::FLG_DEC_PCM], s.flags[chr_pkg::FLG_DEC_ADM]};

    unique case (acByte)
      chr_pkg::ADDR_STATUS:  rdWord = {statusByte, 8'h00};
      chr_pkg::ADDR_DEC_ENV: rdWord = nonPos(dpIn.decEnvLevel);
      chr_pkg::ADDR_DEC_OFS: rdWord = dpIn.decOffsetLevel;
      chr_pkg::ADDR_DEC_PCM: rdWord = s.decPcm;
      chr_pkg::ADDR_DEC_ADM: rdWord = {s.decAdm, 8'h00};
      chr_pkg::ADDR_ENC_ENV: rdWord = nonPos(dpIn.encEnvLevel);
      chr_pkg::ADDR_ENC_EST: rdWord = s.offEst;
      default:               rdWord = chr_pkg::ZERO16;
    endcase

    // ==========================================================================
    // Serial host transfer: address byte, then data bits MSB first.
    if (s.csLvl) begin
      next_s.phase = chr_pkg::PH_ADDR;
      next_s.bitCnt = '0;
      next_s.replyOe = 1'b0;
    end else if (sckRise) begin
      next_s.shiftIn = wrWord;
      next_s.bitCnt = s.bitCnt + 5'h01;
      unique case (s.phase)
        chr_pkg::PH_ADDR: begin
          if (s.bitCnt == chr_pkg::ADDR_LAST) begin
            next_s.addr = acByte;
            next_s.bitCnt = '0;
            next_s.dataBits = accessBits(acByte);
            if (acByte == chr_pkg::ADDR_STATUS) begin
              irqClr = 1'b1;
            end
            flagClr[chr_pkg::FLG_DEC_PCM] = (acByte == chr_pkg::ADDR_DEC_PCM);
            flagClr[chr_pkg::FLG_DEC_ADM] = (acByte == chr_pkg::ADDR_DEC_ADM);
            flagClr[chr_pkg::FLG_ENC_PCM] = (acByte == chr_pkg::ADDR_ENC_PCM);
            flagClr[chr_pkg::FLG_ENC_ADM] = (acByte == chr_pkg::ADDR_ENC_ADMO) ||
                                            (acByte == chr_pkg::ADDR_ENC_ADMT);
            if (accessBits(acByte) == chr_pkg::BITS_NONE) begin
              next_s.phase = chr_pkg::PH_ADDR;
            end else if (isWrite(acByte)) begin
              next_s.phase = chr_pkg::PH_WDATA;
            end else begin
              next_s.phase = chr_pkg::PH_RDATA;
              next_s.shiftOut = rdWord;
              next_s.replyOe = 1'b1;
            end
          end
        end
        chr_pkg::PH_WDATA: begin
          if (s.bitCnt == s.dataBits - 5'h01) begin
            next_s.phase = chr_pkg::PH_SKIP;
            unique case (s.addr)
              chr_pkg::ADDR_ENC_THR: begin
                next_s.enc.vadThreshold = wrWord[15] ? chr_pkg::THR_MAX : wrWord;
              end
              chr_pkg::ADDR_ENC_OFS: begin
                next_s.encOffset = wrWord;
                if (!(dpIn.offCompEn && wrWord == chr_pkg::ZERO16)) begin
                  next_s.offEst = wrWord;
                end
              end
              chr_pkg::ADDR_ENC_CONV: begin
                next_s.enc.convWord = wrWord;
                next_s.enc.convStrobe = 1'b1;
              end
              chr_pkg::ADDR_ENC_ADMT: begin
                next_s.enc.admTestByte = wrWord[7:0];
                next_s.enc.admTestStrobe = 1'b1;
              end
              default: begin
                next_s.phase = chr_pkg::PH_SKIP;
              end
            endcase
          end
        end
        chr_pkg::PH_RDATA: begin
          if (s.bitCnt == s.dataBits - 5'h01) begin
            next_s.phase = chr_pkg::PH_SKIP;
          end
        end
        chr_pkg::PH_SKIP: begin
          next_s.bitCnt = s.bitCnt;
        end
      endcase
    end else if (sckFall && s.phase == chr_pkg::PH_RDATA) begin
      next_s.replyData = s.shiftOut[15];
      next_s.shiftOut = {s.shiftOut[14:0], 1'b0};
    end

    // ==========================================================================
    // Encoder offset path; a zero offset with compensation on holds the estimate.
    adj = satAdd(dpIn.encSample, s.offEst);
    if (dpIn.encSampleValid) begin
      next_s.enc.encAdjSample = adj;
      next_s.enc.encAdjValid = 1'b1;
      if (dpIn.offCompEn && s.encOffset != chr_pkg::ZERO16) begin
        next_s.offEst = satAdd(s.offEst, adj[15] ? chr_pkg::ONE16 : chr_pkg::MINUS1_16);
      end
    end

    // ==========================================================================
    // Decoder read-back data.
    if (dpIn.decPcmValid) begin
      next_s.decPcm = dpIn.decPcm;
      flagSet[chr_pkg::FLG_DEC_PCM] = dpIn.decTranscode;
      irqSet = irqSet | dpIn.intCtrl[chr_pkg::INT_DEC_PCM];
    end
    if (dpIn.decAdmBitValid) begin
      next_s.admShift = {s.admShift[6:0], dpIn.decAdmBit};
      next_s.admCnt = s.admCnt + 3'h1;
      if (s.admCnt == chr_pkg::ADM_LAST) begin
        next_s.decAdm = {s.admShift[6:0], dpIn.decAdmBit};
        flagSet[chr_pkg::FLG_DEC_ADM] = dpIn.decTranscode;
        irqSet = irqSet | dpIn.intCtrl[chr_pkg::INT_DEC_ADM];
      end
    end
    flagSet[chr_pkg::FLG_ENC_ADM] = flagSet[chr_pkg::FLG_ENC_ADM] | dpIn.encAdmTaken;

    // ==========================================================================
    // Flags and interrupt request; a set in the clearing cycle wins.
    flagSet = flagSet | dpIn.flagEvent;
    flagIntEn = {dpIn.intCtrl[chr_pkg::INT_ENC_PCM], dpIn.intCtrl[chr_pkg::INT_ENC_ADM],
                 dpIn.intCtrl[chr_pkg::INT_DEC_PCM], dpIn.intCtrl[chr_pkg::INT_DEC_ADM]};
    next_s.flags = (s.flags & ~flagClr) | flagSet;
    next_s.voice = {dpIn.encVoice, dpIn.decVoice};
    irqSet = irqSet || (|(flagSet & flagIntEn)) || (next_s.voice != s.voice);
    next_s.irq = (s.irq && !irqClr) || irqSet;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= chr_pkg::ST_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  assign replyData = s.replyData;
  assign replyOe = s.replyOe;
  assign irq = s.irq;
  assign encOut = s.enc;

endmodule : chr_regs

/* tb/chr_regs_assertions.sv */
// Purpose: Port-level checker for the codec host register bank.
// Assumes: One clock domain, nrst asynchronous active low.
// Notes: Bound to chr_regs after the module.
`timescale 1ns/10ps
module chr_regs_assertions (
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire logic                  csN,
  input wire logic                  serialClk,
  input wire logic                  cmdData,
  input wire logic                  replyData,
  input wire logic                  replyOe,
  input wire logic                  irq,
  input wire chr_pkg::chr_dp_in_t   dpIn,
  input wire chr_pkg::chr_enc_out_t encOut
);
  logic [2:0] admCnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // Counts decoder ADM bits so the byte boundary is known.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) admCnt <= 3'h0;
    else if (dpIn.decAdmBitValid) admCnt <= admCnt + 3'h1;
  end
  a_adj_follows: assert property (dpIn.encSampleValid |=> encOut.encAdjValid)
    else $error("adjusted sample missing");
  a_adj_cause: assert property (encOut.encAdjValid |-> $past(dpIn.encSampleValid))
    else $error("adjusted sample without input");
  a_thr_limit: assert property (encOut.vadThreshold[15] == 1'b0)
    else $error("threshold above limit");
  a_conv_pulse: assert property (encOut.convStrobe |=> !encOut.convStrobe)
    else $error("converter strobe too long");
  a_admt_pulse: assert property (encOut.admTestStrobe |=> !encOut.admTestStrobe)
    else $error("adm test strobe too long");
  a_pcm_irq: assert property (dpIn.decPcmValid && dpIn.intCtrl[1] |=> irq)
    else $error("pcm update gave no irq");
  a_adm_irq: assert property (dpIn.decAdmBitValid && admCnt == 3'h7 && dpIn.intCtrl[0]
    |=> irq)
    else $error("adm byte gave no irq");
  a_voice_irq: assert property ($changed(dpIn.encVoice) || $changed(dpIn.decVoice)
    |=> irq)
    else $error("voice change gave no irq");
  a_irq_hold: assert property ($fell(irq) |-> !$past(csN, 4))
    else $error("irq dropped without host access");
  a_oe_release: assert property (csN [*6] |-> !replyOe)
    else $error("reply driven while deselected");
  c_irq_clear: cover property ($fell(irq));
  c_conv: cover property (encOut.convStrobe);
  c_adj: cover property (encOut.encAdjValid);
endmodule : chr_regs_assertions

bind chr_regs chr_regs_assertions u_chr_regs_assertions (.clk(clk), .nrst(nrst),
  .csN(csN), .serialClk(serialClk), .cmdData(cmdData), .replyData(replyData),
  .replyOe(replyOe), .irq(irq), .dpIn(dpIn), .encOut(encOut));

/* tb/chr_host_model.sv */
// Purpose: Host controller model driving the serial register bus.
// Assumes: Each phase of the serial clock lasts half clk cycles, 6 unless a test sets it.
// Notes: Data line is inverted when released.
`timescale 1ns/10ps
module chr_host_model (
  input  wire logic clk,
  output logic      csN,
  output logic      serialClk,
  output logic      cmdData,
  input  wire logic replyData,
  input  wire logic replyOe
);
  int half = 6;
  initial begin
    csN = 1'b1;
    serialClk = 1'b0;
    cmdData = 1'b0;
  end
  task automatic hold;
    repeat (half) @(posedge clk);
    #1;
  endtask : hold
  // ==========================================================================
  // Sends an address byte and n data bits, gathering reply bits.
  task automatic xfer(input logic [7:0] a, input int n, input logic [15:0] w,
                      output logic [15:0] r);
    logic [23:0] sh;
    sh = {a, w};
    r = '0;
    csN = 1'b0;
    hold();
    for (int i = 0; i < 8 + n; i++) begin
      cmdData = sh[23-i];
      hold();
      serialClk = 1'b1;
      if (i >= 8) r = {r[14:0], replyOe ? replyData : ~replyData};
      hold();
      serialClk = 1'b0;
    end
    hold();
    csN = 1'b1;
    cmdData = ~cmdData;
    hold();
  endtask : xfer
endmodule : chr_host_model

/* tb/chr_regs_tb_top.sv */
// Purpose: Self-checking bench for the codec host register bank.
// Assumes: Host model drives the serial pins; bench drives the datapath.
// Notes: 8-bit writes carry the byte in the upper half of the word.
`timescale 1ns/10ps
module chr_regs_tb_top;
  logic                  clk;
  logic                  nrst;
  logic                  csN;
  logic                  serialClk;
  logic                  cmdData;
  logic                  replyData;
  logic                  replyOe;
  logic                  irq;
  chr_pkg::chr_dp_in_t   dpIn;
  chr_pkg::chr_enc_out_t encOut;
  int                    fails;
  int                    tests_run;

  chr_regs u_chr_regs (.clk(clk), .nrst(nrst), .csN(csN), .serialClk(serialClk),
    .cmdData(cmdData), .replyData(replyData), .replyOe(replyOe), .irq(irq),
    .dpIn(dpIn), .encOut(encOut));
  chr_host_model u_chr_host_model (.clk(clk), .csN(csN), .serialClk(serialClk),
    .cmdData(cmdData), .replyData(replyData), .replyOe(replyOe));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================================================
  // Shared tasks.
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input int n, input logic [15:0] e, input string nm);
    logic [15:0] r;
    u_chr_host_model.xfer(a, n, 16'h0000, r);
    chk(nm, e, r);
  endtask : rd
  task automatic wr(input logic [7:0] a, input int n, input logic [15:0] w);
    logic [15:0] r;
    u_chr_host_model.xfer(a, n, w, r);
  endtask : wr
  task automatic give_verdict;
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // ==========================================================================
  // Scenarios.
  task automatic t_status;
    dpIn.intCtrl = 8'h33;
    dpIn.flagEvent = 4'hf;
    tick();
    dpIn.flagEvent = 4'h0;
    dpIn.encVoice = 1'b1;
    repeat (20) tick();
    chk("irq held", 16'h0001, {15'h0, irq});
    rd(8'h80, 8, 16'h0073, "status");
    chk("irq cleared", 16'h0000, {15'h0, irq});
    rd(8'he6, 16, 16'h0000, "enc pcm");
    rd(8'hea, 8, 16'h0000, "enc adm");
    rd(8'hd6, 16, 16'h0000, "dec pcm");
    rd(8'hda, 8, 16'h0000, "dec adm");
    rd(8'h80, 8, 16'h0040, "status cleared");
  endtask : t_status
  task automatic t_decoder;
    logic [7:0] b;
    b = 8'hb2;
    dpIn.intCtrl = 8'h02;
    dpIn.decPcm = 16'ha5c3;
    dpIn.decPcmValid = 1'b1;
    tick();
    dpIn.decPcmValid = 1'b0;
    chk("pcm irq", 16'h0001, {15'h0, irq});
    rd(8'hd6, 16, 16'ha5c3, "dec pcm");
    rd(8'h80, 8, 16'h0040, "status pcm");
    dpIn.intCtrl = 8'h01;
    dpIn.decTranscode = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      chk("adm early irq", 16'h0000, {15'h0, irq});
      dpIn.decAdmBit = b[i];
      dpIn.decAdmBitValid = 1'b1;
      tick();
    end
    dpIn.decAdmBitValid = 1'b0;
    chk("adm irq", 16'h0001, {15'h0, irq});
    rd(8'h80, 8, 16'h0041, "status adm");
    rd(8'hda, 8, 16'h00b2, "dec adm");
    dpIn.decTranscode = 1'b0;
  endtask : t_decoder
  task automatic t_levels;
    dpIn.decEnvLevel = 16'h0005;
    dpIn.encEnvLevel = 16'h8000;
    dpIn.decOffsetLevel = 16'h8001;
    u_chr_host_model.half = 4;
    rd(8'hd4, 16, 16'h0000, "dec env");
    rd(8'he4, 16, 16'h8000, "enc env");
    rd(8'hd5, 16, 16'h8001, "dec offset");
    u_chr_host_model.half = 6;
  endtask : t_levels
  task automatic t_writes;
    wr(8'he7, 16, 16'h8001);
    chk("conv word", 16'h8001, encOut.convWord);
    wr(8'he2, 16, 16'h8000);
    chk("threshold sat", 16'h7fff, encOut.vadThreshold);
    wr(8'he2, 16, 16'h1234);
    chk("threshold", 16'h1234, encOut.vadThreshold);
    wr(8'he8, 8, 16'h5a00);
    chk("adm test", 16'h005a, {8'h00, encOut.admTestByte});
    dpIn.intCtrl = 8'h10;
    dpIn.encAdmTaken = 1'b1;
    tick();
    dpIn.encAdmTaken = 1'b0;
    chk("refill irq", 16'h0001, {15'h0, irq});
    rd(8'h80, 8, 16'h0050, "status refill");
  endtask : t_writes
  task automatic sample(input logic [15:0] s, input logic [15:0] e, input string nm);
    dpIn.encSample = s;
    dpIn.encSampleValid = 1'b1;
    tick();
    dpIn.encSampleValid = 1'b0;
    chk(nm, e, encOut.encAdjSample);
  endtask : sample
  task automatic t_offset;
    wr(8'he3, 16, 16'h0004);
    sample(16'h1000, 16'h1004, "adj sum");
    sample(16'h7ffe, 16'h7fff, "adj sat");
    rd(8'he5, 16, 16'h0004, "estimate");
    dpIn.offCompEn = 1'b1;
    sample(16'h1000, 16'h1004, "adj comp");
    rd(8'he5, 16, 16'h0003, "estimate step");
    wr(8'he3, 16, 16'h0000);
    sample(16'h1000, 16'h1003, "adj frozen");
    rd(8'he5, 16, 16'h0003, "estimate frozen");
    dpIn.offCompEn = 1'b0;
    wr(8'he3, 16, 16'h0000);
    sample(16'h1000, 16'h1000, "adj off");
  endtask : t_offset
  // ==========================================================================
  // Main sequence and watchdog.
  initial begin
    fails = 0;
    tests_run = 0;
    dpIn = '0;
    nrst = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (4) tick();
    chk("reset outputs", 16'h0000, {14'h0, irq, replyOe});
    chk("reset conv", 16'h0000, encOut.convWord);
    t_status();
    t_decoder();
    t_levels();
    t_writes();
    t_offset();
    give_verdict();
  end
  initial begin
    #400000;
    fails++;
    give_verdict();
  end
endmodule : chr_regs_tb_top
